// [nvm_autoload_params.svh]
// Constants of the nonvolatile loader and EEPROM access logic
`ifndef NVM_AUTOLOAD_PARAMS_SVH
`define NVM_AUTOLOAD_PARAMS_SVH
`define REG_PAGE 2'h3
`define OFF_ACC_CTRL 4'h2
`define OFF_ADDR_DATA 4'h4
`define BIT_START 7
`define BIT_WNR 6
`define SIG_ADDR 17'h00FF4
`define RING_TOP 17'h03FFF
`define LOAD_BASE 17'h04000
`define CIS_BASE 17'h04010
`define SRAM_TOP 17'h07FFF
`define ATTR_LIMIT 17'h03FFF
`define COMMON_LIMIT 17'h1FFFF
`define EE_COUNT_WORD 8'h00
`define EE_ID_WORD 8'h01
`define EE_CIS_WORD 8'h05
`define CIS_MAX_WORDS 8'hF6
`define OPC_READ 3'h6
`define OPC_WRITE 3'h5
`define OPC_EWEN 3'h4
`define EWEN_ADDR 8'hC0
`define LEN_CMD 5'h0B
`define LEN_WRITE 5'h1B
`define LEN_READ 5'h1B
`define CLK_MHZ 125
`define SK_HALF_NS 500
`define SK_HALF_CYC ((`SK_HALF_NS * `CLK_MHZ + 999) / 1000)
`define LOAD_LIMIT_US 10000
`define LOAD_LIMIT_CYC (`LOAD_LIMIT_US * `CLK_MHZ)
`endif

// [nvm_autoload_pkg.sv]
// Types of the nonvolatile loader and EEPROM access logic
package nvm_autoload_pkg;
  typedef enum logic [2:0] {
    L_STRAP = 3'h0, L_ISSUE = 3'h1, L_WAIT = 3'h3,
    L_WLO = 3'h2, L_WHI = 3'h6, L_READY = 3'h7
  } load_state_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ADDR = 2'h1, S_DATA = 2'h3, S_RUN = 2'h2} seq_state_t;
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_EWEN = 2'h3} nvm_op_t;
  typedef enum logic [1:0] {E_IDLE = 2'h0, E_SHIFT = 2'h1, E_GAP = 2'h3, E_POLL = 2'h2} eng_state_t;
  typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_SIG = 2'h1, SRC_MEM = 2'h3} rd_src_t;
  typedef struct packed {
    eng_state_t phase;
    logic [6:0] div;
    logic [4:0] nbits;
    logic [4:0] len;
    logic [26:0] tx;
    logic [15:0] rx;
    logic cs;
    logic sk;
    logic di;
    logic done;
    logic wr;
  } eng_st_t;
  typedef struct packed {
    load_state_t lstate;
    seq_state_t sstate;
    logic strap_flash;
    logic [7:0] idx;
    logic [7:0] cis_cnt;
    logic [15:0] data;
    logic [20:0] timer;
    logic ctrl_start;
    logic ctrl_wnr;
    logic [15:0] holder;
    logic [7:0] seq_addr;
    logic ewen_pend;
    logic eng_start;
    nvm_op_t eng_op;
    logic [7:0] eng_addr;
    logic sig_odd;
    logic m_busy;
    logic m_wr;
    rd_src_t m_src;
    logic mem_ack;
    logic [7:0] mem_rdata;
    logic [16:0] local_mem_addr_bus;
    logic [7:0] local_mem_data_bus;
    logic sram_cs_b;
    logic flash_cs_b;
    logic mem_oe_b;
    logic mem_we_b;
    logic host_irq_busy_b;
    logic [15:0] io_rdata;
  } top_st_t;
endpackage

// [nvm_serial_word.sv]
// Three-wire serial EEPROM word engine: read, write, erase/write enable
`include "nvm_autoload_params.svh"
module nvm_serial_word (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire nvm_autoload_pkg::nvm_op_t op,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ser_do,
  output logic done,
  output logic busy,
  output logic [15:0] rdata,
  output logic ser_cs,
  output logic ser_sk,
  output logic ser_di
);
  nvm_autoload_pkg::eng_st_t s;
  nvm_autoload_pkg::eng_st_t next_s;
  logic half;

  assign half = s.div == 7'(`SK_HALF_CYC - 1);

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.phase)
      nvm_autoload_pkg::E_IDLE: begin
        if (start) begin
          case (op)
            nvm_autoload_pkg::OP_READ: begin
              next_s.tx = {`OPC_READ, addr, 16'h0000};
              next_s.len = `LEN_READ;
            end
            nvm_autoload_pkg::OP_WRITE: begin
              next_s.tx = {`OPC_WRITE, addr, wdata};
              next_s.len = `LEN_WRITE;
            end
            default: begin
              next_s.tx = {`OPC_EWEN, `EWEN_ADDR, 16'h0000};
              next_s.len = `LEN_CMD;
            end
          endcase
          next_s.wr = op == nvm_autoload_pkg::OP_WRITE;
          next_s.nbits = 5'h00;
          next_s.div = 7'h00;
          next_s.cs = 1'b1;
          next_s.sk = 1'b0;
          next_s.di = 1'b1;
          next_s.phase = nvm_autoload_pkg::E_SHIFT;
        end
      end
      nvm_autoload_pkg::E_SHIFT: begin
        next_s.div = s.div + 7'h01;
        if (half) begin
          next_s.div = 7'h00;
          next_s.sk = !s.sk;
          // Sampled on the falling edge, where the part's output is settled
          if (s.sk) begin
            next_s.rx = {s.rx[14:0], ser_do};
            next_s.nbits = s.nbits + 5'h01;
            next_s.tx = {s.tx[25:0], 1'b0};
            next_s.di = s.tx[25];
            if (s.nbits + 5'h01 == s.len) begin
              next_s.cs = 1'b0;
              next_s.di = 1'b0;
              next_s.phase = s.wr ? nvm_autoload_pkg::E_GAP : nvm_autoload_pkg::E_IDLE;
              next_s.done = !s.wr;
            end
          end
        end
      end
      nvm_autoload_pkg::E_GAP: begin
        next_s.div = s.div + 7'h01;
        if (half) begin
          next_s.div = 7'h00;
          next_s.cs = 1'b1;
          next_s.phase = nvm_autoload_pkg::E_POLL;
        end
      end
      nvm_autoload_pkg::E_POLL: begin
        // Ready shows as data-out high once the internal write ends
        // Data-out is not trusted until half an SK period after select rises
        if (!half) begin
          next_s.div = s.div + 7'h01;
        end else if (ser_do) begin
          next_s.cs = 1'b0;
          next_s.done = 1'b1;
          next_s.phase = nvm_autoload_pkg::E_IDLE;
        end
      end
      default: next_s.phase = nvm_autoload_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign busy = s.phase != nvm_autoload_pkg::E_IDLE;
  assign rdata = s.rx;
  assign ser_cs = s.cs;
  assign ser_sk = s.sk;
  assign ser_di = s.di;
endmodule

// [nvm_mem_decode.sv]
// Host memory window decode: signature, SRAM, flash and write protection
`include "nvm_autoload_params.svh"
module nvm_mem_decode (
  input wire logic strap_flash,
  input wire logic attr,
  input wire logic wr,
  input wire logic flash_wen,
  input wire logic [16:0] addr,
  output logic sig_hit,
  output logic sram_hit,
  output logic flash_hit,
  output logic wr_drop,
  output logic [16:0] phys
);
  always_comb begin
    sig_hit = attr && addr == `SIG_ADDR;
    sram_hit = 1'b0;
    flash_hit = 1'b0;
    wr_drop = 1'b0;
    phys = addr;
    if (strap_flash) begin
      flash_hit = !sig_hit && (attr ? addr <= `ATTR_LIMIT :
                  addr > `ATTR_LIMIT && addr <= `COMMON_LIMIT);
      sram_hit = !attr && addr <= `RING_TOP;
      wr_drop = wr && flash_hit && !flash_wen;
    end else begin
      if (attr) begin
        phys = `CIS_BASE + {1'b0, addr[16:1]};
        sram_hit = !sig_hit;
      end else begin
        sram_hit = addr <= `SRAM_TOP;
      end
      wr_drop = wr && sram_hit && phys >= `LOAD_BASE;
    end
  end
endmodule

// [nvm_autoload.sv]
// Power-on loader, EEPROM word access and memory decode of the card
`include "nvm_autoload_params.svh"
module nvm_autoload #(
  parameter int LOAD_LIMIT_CYCLES = `LOAD_LIMIT_CYC,
  // Arbitrary identification value
  parameter logic [7:0] CHIP_ID = 8'h5A
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic nvm_select_strap,
  input wire logic flash_write_enable_bit,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_page,
  input wire logic [3:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic mem_req,
  input wire logic mem_attr,
  input wire logic mem_wr,
  input wire logic [16:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  output logic [16:0] local_mem_addr_bus,
  output logic [7:0] local_mem_data_bus,
  input wire logic [7:0] local_mem_data_in,
  output logic sram_cs_b,
  output logic flash_cs_b,
  output logic mem_oe_b,
  output logic mem_we_b,
  output logic host_irq_busy_b,
  output logic eeprom_cs,
  output logic eeprom_sk,
  output logic eeprom_di,
  input wire logic eeprom_do
);
  nvm_autoload_pkg::top_st_t s;
  nvm_autoload_pkg::top_st_t next_s;
  logic eng_done;
  logic eng_busy;
  logic [15:0] eng_rdata;
  logic sig_hit;
  logic sram_hit;
  logic flash_hit;
  logic wr_drop;
  logic [16:0] phys;
  logic hit_ctrl;
  logic hit_hold;
  logic io_any;
  logic ctrl_ok;
  logic [7:0] cnt_clamped;

  function automatic logic is_reg(input logic [1:0] pg, input logic [3:0] ad, input logic [3:0] off);
    return pg == `REG_PAGE && ad == off;
  endfunction

  // Word 1..4 carry IDs, board type, checksum; later words the card info
  function automatic logic [16:0] load_addr(input logic [7:0] idx);
    logic [7:0] k;
    k = idx - `EE_CIS_WORD;
    if (idx < `EE_CIS_WORD) begin
      k = idx - `EE_ID_WORD;
      return `LOAD_BASE + {8'h00, k, 1'b0};
    end
    return `CIS_BASE + {8'h00, k, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  nvm_serial_word u_word (
    .clk(clk),
    .rst_b(rst_b),
    .start(s.eng_start),
    .op(s.eng_op),
    .addr(s.eng_addr),
    .wdata(s.holder),
    .ser_do(eeprom_do),
    .done(eng_done),
    .busy(eng_busy),
    .rdata(eng_rdata),
    .ser_cs(eeprom_cs),
    .ser_sk(eeprom_sk),
    .ser_di(eeprom_di)
  );

  nvm_mem_decode u_dec (
    .strap_flash(s.strap_flash),
    .attr(mem_attr),
    .wr(mem_wr),
    .flash_wen(flash_write_enable_bit),
    .addr(mem_addr),
    .sig_hit(sig_hit),
    .sram_hit(sram_hit),
    .flash_hit(flash_hit),
    .wr_drop(wr_drop),
    .phys(phys)
  );

  assign hit_ctrl = is_reg(io_page, io_addr, `OFF_ACC_CTRL);
  assign hit_hold = is_reg(io_page, io_addr, `OFF_ADDR_DATA);
  assign io_any = io_wr || io_rd;
  assign ctrl_ok = !s.strap_flash && s.lstate == nvm_autoload_pkg::L_READY;
  assign cnt_clamped = eng_rdata[7:0] > `CIS_MAX_WORDS ? `CIS_MAX_WORDS : eng_rdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.eng_start = 1'b0;
    next_s.mem_ack = 1'b0;
    next_s.sram_cs_b = 1'b1;
    next_s.flash_cs_b = 1'b1;
    next_s.mem_oe_b = 1'b1;
    next_s.mem_we_b = 1'b1;

    // Loader: entered only through the hardware reset value of lstate
    case (s.lstate)
      nvm_autoload_pkg::L_STRAP: begin
        next_s.strap_flash = nvm_select_strap;
        next_s.idx = `EE_COUNT_WORD;
        next_s.lstate = nvm_select_strap ? nvm_autoload_pkg::L_READY : nvm_autoload_pkg::L_ISSUE;
      end
      nvm_autoload_pkg::L_ISSUE: begin
        if (!eng_busy) begin
          next_s.eng_start = 1'b1;
          next_s.eng_op = nvm_autoload_pkg::OP_READ;
          next_s.eng_addr = s.idx;
          next_s.lstate = nvm_autoload_pkg::L_WAIT;
        end
      end
      nvm_autoload_pkg::L_WAIT: begin
        if (eng_done) begin
          next_s.data = eng_rdata;
          if (s.idx == `EE_COUNT_WORD) begin
            next_s.cis_cnt = cnt_clamped;
            next_s.idx = `EE_ID_WORD;
            next_s.lstate = nvm_autoload_pkg::L_ISSUE;
          end else begin
            next_s.lstate = nvm_autoload_pkg::L_WLO;
          end
        end
      end
      nvm_autoload_pkg::L_WLO: begin
        next_s.local_mem_addr_bus = load_addr(s.idx);
        next_s.local_mem_data_bus = s.data[7:0];
        next_s.sram_cs_b = 1'b0;
        next_s.mem_we_b = 1'b0;
        next_s.lstate = nvm_autoload_pkg::L_WHI;
      end
      nvm_autoload_pkg::L_WHI: begin
        next_s.local_mem_addr_bus = load_addr(s.idx) + 17'h00001;
        next_s.local_mem_data_bus = s.data[15:8];
        next_s.sram_cs_b = 1'b0;
        next_s.mem_we_b = 1'b0;
        next_s.idx = s.idx + 8'h01;
        if (s.idx + 8'h01 == `EE_CIS_WORD + s.cis_cnt) begin
          next_s.lstate = nvm_autoload_pkg::L_READY;
        end else begin
          next_s.lstate = nvm_autoload_pkg::L_ISSUE;
        end
      end
      nvm_autoload_pkg::L_READY: next_s.timer = s.timer;
      default: next_s.lstate = nvm_autoload_pkg::L_READY;
    endcase

    // Hard ceiling on the load, whatever the card information length
    if (s.lstate != nvm_autoload_pkg::L_READY) begin
      next_s.timer = s.timer + 21'h000001;
      if (s.timer == 21'(LOAD_LIMIT_CYCLES - 1)) begin
        next_s.lstate = nvm_autoload_pkg::L_READY;
      end
    end
    next_s.host_irq_busy_b = next_s.lstate == nvm_autoload_pkg::L_READY;

    //////////////////////////////////////////////////////////////////////////
    // Register reads; inhibited control register reads as zero
    if (io_rd) begin
      if (hit_ctrl && ctrl_ok) begin
        next_s.io_rdata = {8'h00, s.ctrl_start, s.ctrl_wnr, 6'h00};
      end else if (hit_hold) begin
        next_s.io_rdata = s.holder;
      end else begin
        next_s.io_rdata = 16'h0000;
      end
    end

    case (s.sstate)
      nvm_autoload_pkg::S_IDLE: begin
        if (io_wr && hit_hold) begin
          next_s.holder = io_wdata;
        end
        if (io_wr && hit_ctrl && ctrl_ok) begin
          next_s.ctrl_wnr = io_wdata[`BIT_WNR];
          // A new start is dropped, not queued, while an aborted frame is still on the wire
          if (io_wdata[`BIT_START] && !eng_busy) begin
            next_s.ctrl_start = 1'b1;
            next_s.sstate = nvm_autoload_pkg::S_ADDR;
          end
        end
      end
      nvm_autoload_pkg::S_ADDR: begin
        if (io_wr && hit_hold) begin
          next_s.holder = io_wdata;
          next_s.seq_addr = io_wdata[7:0];
          if (s.ctrl_wnr) begin
            next_s.sstate = nvm_autoload_pkg::S_DATA;
          end else begin
            next_s.eng_start = 1'b1;
            next_s.eng_op = nvm_autoload_pkg::OP_READ;
            next_s.eng_addr = io_wdata[7:0];
            next_s.sstate = nvm_autoload_pkg::S_RUN;
          end
        end else if (io_any) begin
          next_s.ctrl_start = 1'b0;
          next_s.sstate = nvm_autoload_pkg::S_IDLE;
        end
      end
      nvm_autoload_pkg::S_DATA: begin
        if (io_wr && hit_hold) begin
          next_s.holder = io_wdata;
          next_s.eng_start = 1'b1;
          next_s.eng_op = nvm_autoload_pkg::OP_EWEN;
          next_s.ewen_pend = 1'b1;
          next_s.sstate = nvm_autoload_pkg::S_RUN;
        end else if (io_any) begin
          next_s.ctrl_start = 1'b0;
          next_s.sstate = nvm_autoload_pkg::S_IDLE;
        end
      end
      nvm_autoload_pkg::S_RUN: begin
        if (eng_done) begin
          if (s.ewen_pend) begin
            next_s.ewen_pend = 1'b0;
            next_s.eng_start = 1'b1;
            next_s.eng_op = nvm_autoload_pkg::OP_WRITE;
            next_s.eng_addr = s.seq_addr;
          end else begin
            if (!s.ctrl_wnr) begin
              next_s.holder = eng_rdata;
            end
            next_s.ctrl_start = 1'b0;
            next_s.sstate = nvm_autoload_pkg::S_IDLE;
          end
        end
        // Only polling of the control register keeps the sequence alive
        if (io_any && !(io_rd && hit_ctrl)) begin
          next_s.ctrl_start = 1'b0;
          next_s.ewen_pend = 1'b0;
          next_s.sstate = nvm_autoload_pkg::S_IDLE;
        end
      end
      default: next_s.sstate = nvm_autoload_pkg::S_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Host memory port; requests are not taken while the load runs
    if (s.m_busy) begin
      next_s.m_busy = 1'b0;
      next_s.mem_ack = 1'b1;
      if (s.m_src == nvm_autoload_pkg::SRC_MEM && !s.m_wr) begin
        next_s.mem_rdata = local_mem_data_in;
      end
      // A request still standing on its ack edge is the one just served
    end else if (mem_req && !s.mem_ack && s.lstate == nvm_autoload_pkg::L_READY) begin
      next_s.m_busy = 1'b1;
      next_s.m_wr = mem_wr;
      next_s.m_src = nvm_autoload_pkg::SRC_NONE;
      next_s.mem_rdata = 8'h00;
      next_s.local_mem_addr_bus = phys;
      next_s.local_mem_data_bus = mem_wdata;
      if (sig_hit) begin
        next_s.m_src = nvm_autoload_pkg::SRC_SIG;
        if (!mem_wr) begin
          next_s.sig_odd = !s.sig_odd;
          next_s.mem_rdata = s.sig_odd ? CHIP_ID : 8'h00;
        end
      end else if ((sram_hit || flash_hit) && !wr_drop) begin
        next_s.m_src = nvm_autoload_pkg::SRC_MEM;
        next_s.sram_cs_b = !sram_hit;
        next_s.flash_cs_b = !flash_hit;
        next_s.mem_we_b = !mem_wr;
        next_s.mem_oe_b = mem_wr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.sram_cs_b <= 1'b1;
      s.flash_cs_b <= 1'b1;
      s.mem_oe_b <= 1'b1;
      s.mem_we_b <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign io_rdata = s.io_rdata;
  assign mem_rdata = s.mem_rdata;
  assign mem_ack = s.mem_ack;
  assign local_mem_addr_bus = s.local_mem_addr_bus;
  assign local_mem_data_bus = s.local_mem_data_bus;
  assign sram_cs_b = s.sram_cs_b;
  assign flash_cs_b = s.flash_cs_b;
  assign mem_oe_b = s.mem_oe_b;
  assign mem_we_b = s.mem_we_b;
  assign host_irq_busy_b = s.host_irq_busy_b;
endmodule

// [nvm_autoload_props.sv]
// Port checker of the loader, EEPROM access and memory decode block
module nvm_autoload_props #(
  parameter int LOAD_LIMIT_CYCLES = 1250000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic nvm_select_strap,
  input wire logic flash_write_enable_bit,
  input wire logic mem_req,
  input wire logic mem_attr,
  input wire logic mem_wr,
  input wire logic [16:0] mem_addr,
  input wire logic mem_ack,
  input wire logic flash_cs_b,
  input wire logic mem_we_b,
  input wire logic host_irq_busy_b,
  input wire logic eeprom_cs
);
  timeunit 1ns;
  timeprecision 1ps;
  int since;
  int frame_len;
  // Saturates so a long run never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since <= 0;
    end else if (since < LOAD_LIMIT_CYCLES + 4) begin
      since <= since + 1;
    end
  end
  // Cycles with the serial select high, held at the ceiling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_len <= 0;
    end else if (!eeprom_cs) begin
      frame_len <= 0;
    end else if (frame_len < 4000) begin
      frame_len <= frame_len + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_two_after: assert property ($rose(mem_req) && host_irq_busy_b |-> ##2 mem_ack)
    else $error("memory ack not two cycles after request");
  a_protect_load_area: assert property ($rose(mem_req) && mem_wr && !nvm_select_strap
    && (mem_attr || mem_addr >= 17'h04000) |-> ##1 mem_we_b) else $error("write strobe in load area");
  a_flash_write_lock: assert property ($rose(mem_req) && mem_wr && !flash_write_enable_bit |-> ##1 flash_cs_b)
    else $error("flash selected for a locked write");
  a_flash_attr_select: assert property ($rose(mem_req) && !mem_wr && mem_attr && nvm_select_strap
    && host_irq_busy_b && mem_addr <= 17'h03FFF && mem_addr != 17'h00FF4 |-> ##1 !flash_cs_b)
    else $error("flash not selected for attribute read");
  a_eeprom_quiet_flash: assert property (nvm_select_strap && host_irq_busy_b |-> !eeprom_cs)
    else $error("serial select active in flash mode");
  a_flash_busy_release: assert property (nvm_select_strap && since == 2 |-> host_irq_busy_b)
    else $error("busy not released in flash mode");
  a_load_time_bound: assert property (since > LOAD_LIMIT_CYCLES + 1 |-> host_irq_busy_b)
    else $error("load ran past its limit");
  a_busy_stays_off: assert property (host_irq_busy_b |=> host_irq_busy_b)
    else $error("busy returned without a reset");
  a_no_ack_busy: assert property (!host_irq_busy_b |-> !mem_ack)
    else $error("memory ack while loading");
  a_frame_bounded: assert property (frame_len < 4000)
    else $error("serial frame too long");
endmodule
bind nvm_autoload nvm_autoload_props #(.LOAD_LIMIT_CYCLES(LOAD_LIMIT_CYCLES)) props (.*);

// [nvm_far_side.sv]
// Far side model: serial EEPROM word store and the buffer SRAM
module nvm_far_side (
  input wire logic clk,
  input wire logic eeprom_cs,
  input wire logic eeprom_sk,
  input wire logic eeprom_di,
  output logic eeprom_do,
  input wire logic [16:0] local_mem_addr_bus,
  input wire logic [7:0] local_mem_data_bus,
  input wire logic sram_cs_b,
  input wire logic flash_cs_b,
  input wire logic mem_oe_b,
  input wire logic mem_we_b,
  output logic [7:0] local_mem_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ee [256];
  logic [7:0] ram [32768];
  logic [26:0] sh;
  logic [16:0] out;
  logic [7:0] lastd;
  logic [1:0] op;
  logic skq, wen, rd_en;
  int cnt, bsy;
  initial begin
    for (int i = 0; i < 256; i++) ee[i] = {i[7:0], ~i[7:0]};
    ee[0] = 16'h0002;
    ee[5] = 16'hB2A1;
    ee[6] = 16'hD4C3;
    for (int i = 0; i < 32768; i++) ram[i] = 8'hEE;
    {skq, wen, cnt, bsy, lastd, op, sh, out} = '0;
    eeprom_do = 1'b1;
  end
  // Released data lines show the inverse of the last byte, never a held value
  assign rd_en = !mem_oe_b && !(sram_cs_b && flash_cs_b);
  assign local_mem_data_in = rd_en ? ram[local_mem_addr_bus[14:0]] : ~lastd;
  always @(posedge clk) begin
    if (rd_en) lastd <= ram[local_mem_addr_bus[14:0]];
    if (!sram_cs_b && !mem_we_b) ram[local_mem_addr_bus[14:0]] <= local_mem_data_bus;
    if (bsy > 0) bsy--;
    if (!eeprom_cs) begin
      if (cnt == 27 && op == 2'b01 && wen) begin
        ee[sh[23:16]] = sh[15:0];
        bsy = 200;
      end
      {cnt, op} = {32'd0, 2'b11};
      eeprom_do <= ~eeprom_do;
    end else begin
      if (eeprom_sk && !skq) begin
        sh = {sh[25:0], eeprom_di};
        cnt++;
        if (cnt == 11) begin
          op = sh[9:8];
          wen = wen || (op == 2'b00 && sh[7:6] == 2'b11);
          out = {1'b0, ee[sh[7:0]]};
        end else begin
          out = {out[15:0], 1'b1};
        end
      end
      // Busy shows low until the programming time runs out
      eeprom_do <= (op == 2'b10 && cnt >= 11) ? out[16] : (bsy == 0);
    end
    skq = eeprom_sk;
  end
endmodule

// [testbench.sv]
// Self-checking bench of the loader, EEPROM access and memory decode
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SIG = 8'h3C; // Arbitrary signature value
  logic clk, rst_b, strap, flash_write_enable, io_wr, io_rd, mem_req, mem_attr, mem_wr, mem_ack;
  logic scs, fcs, oe, we, busy_b, ecs, esk, edi, edo;
  logic [1:0] pg, io_page;
  logic [3:0] io_addr;
  logic [15:0] io_wdata, io_rdata, v;
  logic [16:0] mem_addr, la;
  logic [7:0] mem_wdata, mem_rdata, ld, lq;
  logic [7:0] cis [5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hEE};
  int errors, total_checks, cyc;
  nvm_autoload #(.LOAD_LIMIT_CYCLES(30000), .CHIP_ID(SIG)) dut (.clk(clk), .rst_b(rst_b),
    .nvm_select_strap(strap), .flash_write_enable_bit(flash_write_enable), .io_wr(io_wr), .io_rd(io_rd),
    .io_page(io_page), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req),
    .mem_attr(mem_attr), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .local_mem_addr_bus(la), .local_mem_data_bus(ld),
    .local_mem_data_in(lq), .sram_cs_b(scs), .flash_cs_b(fcs), .mem_oe_b(oe), .mem_we_b(we),
    .host_irq_busy_b(busy_b), .eeprom_cs(ecs), .eeprom_sk(esk), .eeprom_di(edi), .eeprom_do(edo));
  nvm_far_side far (.clk(clk), .eeprom_cs(ecs), .eeprom_sk(esk), .eeprom_di(edi), .eeprom_do(edo),
    .local_mem_addr_bus(la), .local_mem_data_bus(ld), .sram_cs_b(scs), .flash_cs_b(fcs),
    .mem_oe_b(oe), .mem_we_b(we), .local_mem_data_in(lq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic t_end(input string s);
    $display("test %s ends", s);
  endtask
  task automatic io(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    {io_wr, io_rd, io_page, io_addr, io_wdata} <= {w, !w, pg, a, d};
    @(posedge clk);
    {io_wr, io_rd} <= 2'b00;
    #1 v = io_rdata;
  endtask
  // Ack comes a fixed two edges after the taking edge, so the request drops on it
  task automatic mem(input logic at, input logic w, input logic [16:0] a, input logic [7:0] d);
    @(posedge clk);
    {mem_req, mem_attr, mem_wr, mem_addr, mem_wdata} <= {1'b1, at, w, a, d};
    repeat (3) @(posedge clk);
    mem_req <= 1'b0;
    #1 v = {8'h00, mem_rdata};
  endtask
  task automatic poll();
    int n;
    n = 0;
    do begin
      io(1'b0, 4'h2, 16'h0000);
      n++;
    end while (v[7] === 1'b1 && n < 3000);
    chk(v & 16'h0080, 16'h0000);
  endtask
  task automatic eeread(input logic [7:0] a);
    io(1'b1, 4'h2, 16'h0080);
    io(1'b1, 4'h4, {8'h00, a});
    io(1'b0, 4'h2, 16'h0000);
    chk(v, 16'h0080);
    poll();
    io(1'b0, 4'h4, 16'h0000);
  endtask
  task automatic sig(input int n);
    for (int k = 0; k < n; k++) begin
      mem(1'b1, 1'b0, 17'h00FF4, 8'h00);
      chk(v, {8'h00, k[0] ? SIG : 8'h00});
    end
  endtask
  task automatic hw_reset(input logic s);
    @(posedge clk);
    rst_b <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    {rst_b, strap, flash_write_enable, io_wr, io_rd, mem_req, mem_attr, mem_wr} = '0;
    {io_page, io_addr, io_wdata, mem_addr, mem_wdata} = '0;
    pg = 2'h3;
    hw_reset(1'b0);
    repeat (20) @(posedge clk);
    chk(16'(busy_b), 16'h0000);
    for (int i = 0; i < 32000 && busy_b !== 1'b1; i++) @(posedge clk);
    chk(16'(busy_b), 16'h0001);
    for (int k = 0; k < 8; k++) begin
      mem(1'b0, 1'b0, 17'h04000 + 17'(k), 8'h00);
      chk(v, {8'h00, k[0] ? 8'(1 + k / 2) : ~8'(1 + k / 2)});
    end
    for (int k = 0; k < 5; k++) begin
      mem(1'b1, 1'b0, 17'(2 * k), 8'h00);
      chk(v, {8'h00, cis[k]});
    end
    sig(3);
    mem(1'b0, 1'b1, 17'h04000, 8'h12);
    mem(1'b0, 1'b0, 17'h04000, 8'h00);
    chk(v, 16'h00FE);
    mem(1'b0, 1'b1, 17'h00010, 8'h34);
    mem(1'b0, 1'b0, 17'h00010, 8'h00);
    chk(v, 16'h0034);
    t_end("load and memory");
    eeread(8'h03);
    chk(v, 16'h03FC);
    io(1'b1, 4'h2, 16'h00C0);
    io(1'b1, 4'h4, 16'h00FF);
    io(1'b1, 4'h4, 16'hBEEF);
    poll();
    eeread(8'hFF);
    chk(v, 16'hBEEF);
    io(1'b0, 4'h4, 16'h0000);
    chk(v, 16'hBEEF);
    t_end("word access");
    io(1'b1, 4'h2, 16'h0080);
    io(1'b1, 4'h4, 16'h0005);
    pg = 2'h0;
    io(1'b0, 4'h0, 16'h0000);
    pg = 2'h3;
    io(1'b0, 4'h2, 16'h0000);
    chk(v & 16'h0080, 16'h0000);
    io(1'b0, 4'h4, 16'h0000);
    chk(v, 16'h0005);
    t_end("abort");
    hw_reset(1'b1);
    repeat (3) @(posedge clk);
    chk(16'(busy_b), 16'h0001);
    io(1'b1, 4'h2, 16'h0080);
    io(1'b0, 4'h2, 16'h0000);
    chk(v, 16'h0000);
    sig(2);
    mem(1'b1, 1'b0, 17'h00100, 8'h00);
    mem(1'b0, 1'b1, 17'h05000, 8'h55);
    @(posedge clk);
    flash_write_enable <= 1'b1;
    mem(1'b0, 1'b1, 17'h05000, 8'h55);
    mem(1'b0, 1'b1, 17'h00020, 8'h66);
    mem(1'b0, 1'b0, 17'h00020, 8'h00);
    chk(v, 16'h0066);
    t_end("flash mode");
    stop_test();
  end
endmodule
